//--- src/shrn_map.svh
`ifndef SHRN_MAP_SVH
`define SHRN_MAP_SVH

// Node identity and offset decode
`define SHRN_NODE_ID 12'h006
`define SHRN_SEL_MSB 6
`define SHRN_Q_NAME 7'h00
`define SHRN_Q_SIZE 7'h01
`define SHRN_Q_RD_LEVEL 7'h02
`define SHRN_Q_WR_LEVEL 7'h03
`define SHRN_Q_TIMEOUT 7'h04
`define SHRN_Q_TYPE 7'h05

// Qualifier values
`define SHRN_DATA_SIZE 16'h0002
`define SHRN_READ_LEVEL 16'h0000
`define SHRN_WRITE_LEVEL 16'h000F
`define SHRN_TYPE_NODE 16'h0000

// Leaf population per access level
`define SHRN_LEAVES_LOW 7'h0B
`define SHRN_LEAVES_PRIV 7'h0C
`define SHRN_PRIV_LEVEL 4'h2
`define SHRN_LEAF_MIN 16'h0200
`define SHRN_LEAF_MAX 16'h02FF

// Error code pairs, first byte high
`define SHRN_ERR_DIR_RD 16'h1340
`define SHRN_ERR_DIR_WR 16'h1441
`define SHRN_ERR_IND_WR 16'h1041
`define SHRN_ERR_NO_LEAF 16'h1440

// Response lengths in bytes
`define SHRN_LEN_NAME 4'h8
`define SHRN_LEN_WORD 4'h2
`define SHRN_LEN_NONE 4'h0

// Sensor channels
`define SHRN_ACCEL_BITS 14
`define SHRN_ACCEL_UG_PER_LSB 12510
`define SHRN_ACCEL_RANGE_G 50
`define SHRN_THERM_BITS 32
`define SHRN_PORT_THERM 1'b0
`define SHRN_PORT_ACCEL 1'b1

`endif

//--- src/shrn_pkg.sv
package shrn_pkg;

    typedef enum logic {SHRN_IDLE, SHRN_ANSWER} shrn_state_t;

    typedef logic [14:0] shrn_offset_t;

    typedef logic [3:0] shrn_level_t;

    typedef logic [63:0] shrn_payload_t;

endpackage

//--- src/shrn_node.sv
// Summary of operation
// R1 - Direct read offsets 0..5 return name, size 2, levels 0/15, timeout, type 00h.
// R2 - Every direct write is refused with error pair 14 41, no state change.
// R3 - Indirect access permission is decided from the requester's access level.
// R4 - Every indirect write is refused as wrong access with error pair 10 41.
// R5 - Indirect offset selects a leaf; unimplemented leaf gives error pair 14 40.
// R6 - Indirect read offset 0 returns leaf count: 000Bh below level 2, 000Ch at level 2 or above.
// R7 - Indirect read offsets 1..count return 2-byte leaf identifiers within 0200h..02FFh.
// R8 - Two-byte answers carry high-order byte in data byte 0, low-order in byte 1.
// R9 - The node reports the identifier of the first hub resource it implements.
// R10 - Hub leaves sit under node 006h, identifiers 200h to 2CCh.
// R11 - Hub resources are served only while the hub function is enabled.
// R12 - Accelerometer samples are 14-bit signed two's-complement values.
// R13 - One accelerometer step is 12.51 mg, range plus or minus 50 g.
// R14 - Thermistor measurement is delivered as a 32-bit unsigned value.
// R15 - Exactly two input-only ports: thermistor is port 0, accelerometer separate.
// R16 - Controller sets accelerometer filter parameters to the frame sampling period.
// R17 - Controller enables the hub by writing 21h to remote register 50h.
// R18 - After power-on the hub is disabled and requests get no answer.
// R19 - Reserved offset bits are ignored; each transaction is answered exactly once.
`timescale 1ns/1ps
`include "shrn_map.svh"

module shrn_node #(
    // Arbitrary name value
    parameter logic [63:0] NODE_NAME = 64'h4E4F_4445_2D30_3030,
    parameter logic [15:0] TIMEOUT = 16'h00FF
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic HUB_ENABLE,
    input wire logic REQ_VALID,
    input wire logic REQ_INDIRECT,
    input wire logic REQ_WRITE,
    input wire shrn_pkg::shrn_offset_t REQ_OFFSET,
    input wire shrn_pkg::shrn_level_t REQ_LEVEL,
    output logic REQ_READY,
    output logic RSP_VALID,
    output logic RSP_ERROR,
    output logic [15:0] RSP_ERR_CODE,
    output logic [3:0] RSP_LENGTH,
    output shrn_pkg::shrn_payload_t RSP_DATA,
    input wire logic ACCEL_VALID,
    input wire logic [13:0] ACCEL_SAMPLE,
    input wire logic THERM_VALID,
    input wire logic [31:0] THERM_SAMPLE,
    output logic [15:0] PORT1_VALUE,
    output logic [31:0] PORT0_VALUE
);
    import shrn_pkg::*;

    shrn_state_t state;
    shrn_state_t next_state;
    logic rsp_valid;
    logic next_rsp_valid;
    logic rsp_error;
    logic next_rsp_error;
    logic [15:0] rsp_err_code;
    logic [15:0] next_rsp_err_code;
    logic [3:0] rsp_length;
    logic [3:0] next_rsp_length;
    shrn_payload_t rsp_data;
    shrn_payload_t next_rsp_data;
    logic [15:0] accel;
    logic [15:0] next_accel;
    logic [31:0] therm;
    logic [31:0] next_therm;

    logic take;
    logic priv;
    logic [6:0] sel;
    logic [6:0] leaf_count;

    // Leaf identifier table; entry 12 only visible at the privileged level
    function automatic logic [15:0] leaf_id(input logic [6:0] idx);
        case (idx)
            7'h01: leaf_id = 16'h0200;
            7'h02: leaf_id = 16'h0201;
            7'h03: leaf_id = 16'h0202;
            7'h04: leaf_id = 16'h0210;
            7'h05: leaf_id = 16'h0280;
            7'h06: leaf_id = 16'h0283;
            7'h07: leaf_id = 16'h0284;
            7'h08: leaf_id = 16'h0285;
            7'h09: leaf_id = 16'h0286;
            7'h0A: leaf_id = 16'h02C0;
            7'h0B: leaf_id = 16'h02CC;
            7'h0C: leaf_id = 16'h0218;
            default: leaf_id = `SHRN_LEAF_MIN;
        endcase
    endfunction

    // Two-byte value placed in data bytes 0 and 1
    function automatic shrn_payload_t word_data(input logic [15:0] value);
        word_data = {value, 48'h0000_0000_0000}; // R8
    endfunction

    assign take = REQ_VALID && REQ_READY;
    assign sel = REQ_OFFSET[`SHRN_SEL_MSB:0]; // R19
    assign priv = (REQ_LEVEL >= `SHRN_PRIV_LEVEL); // R3
    assign leaf_count = priv ? `SHRN_LEAVES_PRIV : `SHRN_LEAVES_LOW; // R3

    always_comb
    begin
        next_state = state;
        next_rsp_valid = 1'b0;
        next_rsp_error = rsp_error;
        next_rsp_err_code = rsp_err_code;
        next_rsp_length = rsp_length;
        next_rsp_data = rsp_data;
        case (state)
            SHRN_IDLE:
            begin
                // Disabled hub drops the request without any answer
                if (take && HUB_ENABLE) // R11 R17 R18
                begin
                    next_state = SHRN_ANSWER;
                    next_rsp_valid = 1'b1; // R19
                    next_rsp_error = 1'b0;
                    next_rsp_err_code = 16'h0000;
                    next_rsp_length = `SHRN_LEN_WORD;
                    next_rsp_data = 64'h0000_0000_0000_0000;
                    if (!REQ_INDIRECT && REQ_WRITE)
                    begin
                        next_rsp_error = 1'b1; // R2
                        next_rsp_err_code = `SHRN_ERR_DIR_WR; // R2
                        next_rsp_length = `SHRN_LEN_NONE;
                    end
                    else if (REQ_INDIRECT && REQ_WRITE)
                    begin
                        next_rsp_error = 1'b1; // R4
                        next_rsp_err_code = `SHRN_ERR_IND_WR; // R4
                        next_rsp_length = `SHRN_LEN_NONE;
                    end
                    else if (!REQ_INDIRECT)
                    begin
                        case (sel)
                            `SHRN_Q_NAME:
                            begin
                                next_rsp_length = `SHRN_LEN_NAME; // R1
                                next_rsp_data = NODE_NAME; // R1
                            end
                            `SHRN_Q_SIZE: next_rsp_data = word_data(`SHRN_DATA_SIZE); // R1
                            `SHRN_Q_RD_LEVEL: next_rsp_data = word_data(`SHRN_READ_LEVEL); // R1
                            `SHRN_Q_WR_LEVEL: next_rsp_data = word_data(`SHRN_WRITE_LEVEL); // R1
                            `SHRN_Q_TIMEOUT: next_rsp_data = word_data(TIMEOUT); // R1
                            `SHRN_Q_TYPE: next_rsp_data = word_data(`SHRN_TYPE_NODE); // R1
                            default:
                            begin
                                next_rsp_error = 1'b1;
                                next_rsp_err_code = `SHRN_ERR_DIR_RD;
                                next_rsp_length = `SHRN_LEN_NONE;
                            end
                        endcase
                    end
                    else if (sel == 7'h00)
                    begin
                        next_rsp_data = word_data({9'h000, leaf_count}); // R6
                    end
                    else if (sel <= leaf_count) // R5
                    begin
                        // Leaves 200h..2CCh under node 006h, first is 200h
                        next_rsp_data = word_data(leaf_id(sel)); // R7 R9 R10
                    end
                    else
                    begin
                        next_rsp_error = 1'b1; // R5
                        next_rsp_err_code = `SHRN_ERR_NO_LEAF; // R5
                        next_rsp_length = `SHRN_LEN_NONE;
                    end
                end
            end
            SHRN_ANSWER:
            begin
                next_state = SHRN_IDLE;
            end
            default:
            begin
                next_state = SHRN_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            state <= SHRN_IDLE;
            rsp_valid <= 1'b0;
            rsp_error <= 1'b0;
            rsp_err_code <= 16'h0000;
            rsp_length <= 4'h0;
            rsp_data <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            state <= next_state;
            rsp_valid <= next_rsp_valid;
            rsp_error <= next_rsp_error;
            rsp_err_code <= next_rsp_err_code;
            rsp_length <= next_rsp_length;
            rsp_data <= next_rsp_data;
        end
    end

    assign REQ_READY = (state == SHRN_IDLE);
    assign RSP_VALID = rsp_valid;
    assign RSP_ERROR = rsp_error;
    assign RSP_ERR_CODE = rsp_err_code;
    assign RSP_LENGTH = rsp_length;
    assign RSP_DATA = rsp_data;

    // Sensor ports: 0 thermistor, 1 accelerometer; captured only while enabled
    always_comb
    begin
        next_accel = accel;
        next_therm = therm;
        if (HUB_ENABLE && ACCEL_VALID) // R11 R15
        begin
            // Sign-extended, 12.51 mg per step over +/-50 g
            next_accel = {{2{ACCEL_SAMPLE[`SHRN_ACCEL_BITS-1]}}, ACCEL_SAMPLE}; // R12 R13
        end
        if (HUB_ENABLE && THERM_VALID) // R11 R15
        begin
            next_therm = THERM_SAMPLE; // R14
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            accel <= 16'h0000;
            therm <= 32'h0000_0000;
        end
        else
        begin
            accel <= next_accel;
            therm <= next_therm;
        end
    end

    assign PORT1_VALUE = accel;
    assign PORT0_VALUE = therm;

    default clocking cb @(posedge MCLK);
    endclocking

    default disable iff (RST);

    a_answer_exactly_once: assert property ( // R19
        take && HUB_ENABLE |=> RSP_VALID ##1 !RSP_VALID)
        else $error("answer not a single pulse after request");

    a_disabled_silent: assert property ( // R18
        take && !HUB_ENABLE |=> !RSP_VALID [*2])
        else $error("answer given while hub disabled");

    a_direct_write_refused: assert property ( // R2
        take && HUB_ENABLE && !REQ_INDIRECT && REQ_WRITE
        |=> RSP_ERROR && (RSP_ERR_CODE == `SHRN_ERR_DIR_WR))
        else $error("direct write not refused with 14 41");

    a_indirect_write_refused: assert property ( // R4
        take && HUB_ENABLE && REQ_INDIRECT && REQ_WRITE
        |=> RSP_ERROR && (RSP_ERR_CODE == `SHRN_ERR_IND_WR))
        else $error("indirect write not refused with 10 41");

    a_count_low_level: assert property ( // R6
        take && HUB_ENABLE && REQ_INDIRECT && !REQ_WRITE && (sel == 7'h00) && (REQ_LEVEL < `SHRN_PRIV_LEVEL)
        |=> !RSP_ERROR && (RSP_DATA[63:48] == 16'h000B))
        else $error("leaf count wrong below level 2");

    a_count_priv_level: assert property ( // R6
        take && HUB_ENABLE && REQ_INDIRECT && !REQ_WRITE && (sel == 7'h00) && (REQ_LEVEL == `SHRN_PRIV_LEVEL)
        |=> !RSP_ERROR && (RSP_DATA[63:48] == 16'h000C))
        else $error("leaf count wrong at level 2");

    a_leaf_in_range: assert property ( // R7
        take && HUB_ENABLE && REQ_INDIRECT && !REQ_WRITE && (sel != 7'h00) && (sel <= leaf_count)
        |=> !RSP_ERROR && (RSP_DATA[63:48] >= `SHRN_LEAF_MIN) && (RSP_DATA[63:48] <= `SHRN_LEAF_MAX)
            && (RSP_DATA[47:0] == 48'h0000_0000_0000))
        else $error("leaf identifier out of range or misplaced");

    a_missing_leaf: assert property ( // R5
        take && HUB_ENABLE && REQ_INDIRECT && !REQ_WRITE && (sel > leaf_count)
        |=> RSP_ERROR && (RSP_ERR_CODE == `SHRN_ERR_NO_LEAF))
        else $error("missing leaf not refused with 14 40");

    a_first_leaf_id: assert property ( // R9
        take && HUB_ENABLE && REQ_INDIRECT && !REQ_WRITE && (sel == 7'h01)
        |=> RSP_DATA[63:56] == 8'h02 && RSP_DATA[55:48] == 8'h00)
        else $error("first leaf identifier wrong");

    a_write_level_qual: assert property ( // R1
        take && HUB_ENABLE && !REQ_INDIRECT && !REQ_WRITE && (sel == `SHRN_Q_WR_LEVEL)
        |=> !RSP_ERROR && (RSP_LENGTH == `SHRN_LEN_WORD) && (RSP_DATA[63:48] == 16'h000F))
        else $error("write level qualifier wrong");

    a_accel_sign_ext: assert property ( // R12
        HUB_ENABLE && ACCEL_VALID
        |=> PORT1_VALUE == {{2{$past(ACCEL_SAMPLE[13])}}, $past(ACCEL_SAMPLE)})
        else $error("accelerometer sample not sign-extended");

    a_disabled_ports_hold: assert property ( // R11
        !HUB_ENABLE |=> $stable(PORT0_VALUE) && $stable(PORT1_VALUE))
        else $error("sensor port changed while hub disabled");

    c_direct_name: cover property (
        take && HUB_ENABLE && !REQ_INDIRECT && !REQ_WRITE && (sel == `SHRN_Q_NAME) ##1 RSP_VALID);

    c_priv_last_leaf: cover property (
        take && HUB_ENABLE && REQ_INDIRECT && priv && (sel == `SHRN_LEAVES_PRIV) ##1 RSP_VALID);

    c_back_to_back: cover property (
        take && HUB_ENABLE ##2 take && HUB_ENABLE);

endmodule

//--- test/shrn_ctrl_model.sv
`timescale 1ns/1ps
module shrn_ctrl_model (
    input wire logic mclk,
    output logic hub_enable,
    output logic req_valid,
    output logic req_indirect,
    output logic req_write,
    output shrn_pkg::shrn_offset_t req_offset,
    output shrn_pkg::shrn_level_t req_level,
    input wire logic req_ready,
    input wire logic rsp_valid
);
    import shrn_pkg::*;
    initial
    begin
        hub_enable = 1'b0;
        req_valid = 1'b0;
        req_indirect = 1'b0;
        req_write = 1'b0;
        req_offset = 15'h0000;
        req_level = 4'h0;
    end
    task automatic set_hub(input logic en);
        @(posedge mclk);
        hub_enable <= en;
    endtask
    task automatic request(input logic ind, input logic wr, input shrn_offset_t off, input shrn_level_t lvl,
                           output bit got);
        int n;
        got = 0;
        n = 0;
        @(posedge mclk);
        req_valid <= 1'b1;
        req_indirect <= ind;
        req_write <= wr;
        req_offset <= off;
        req_level <= lvl;
        // Ready only moves on rising edges, so the falling edge shows the value the next edge samples
        do
        begin
            @(negedge mclk);
            n++;
        end
        while (req_ready !== 1'b1 && n < 16);
        @(posedge mclk);
        // Released lines show garbage, not the old request
        req_valid <= 1'b0;
        req_offset <= ~off;
        req_indirect <= ~ind;
        req_write <= ~wr;
        req_level <= ~lvl;
        for (n = 0; n < 4 && !got; n++)
        begin
            @(negedge mclk);
            got = (rsp_valid === 1'b1);
        end
    endtask
endmodule

//--- test/sensor_hub_resource_node_test.sv
`timescale 1ns/1ps
module sensor_hub_resource_node_test;
    import shrn_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic hub_enable, req_valid, req_indirect, req_write, req_ready, rsp_valid, rsp_error;
    shrn_offset_t req_offset;
    shrn_level_t req_level;
    logic [15:0] rsp_err_code, port1;
    logic [3:0] rsp_length;
    shrn_payload_t rsp_data;
    logic accel_valid = 1'b0;
    logic [13:0] accel_sample = 14'h0000;
    logic therm_valid = 1'b0;
    logic [31:0] therm_sample = 32'h0000_0000;
    logic [31:0] port0, last_t = 32'h0000_0000;
    logic [15:0] last_a = 16'h0000;
    logic [15:0] leaf [13] = '{16'h0000, 16'h0200, 16'h0201, 16'h0202, 16'h0210, 16'h0280, 16'h0283,
                               16'h0284, 16'h0285, 16'h0286, 16'h02C0, 16'h02CC, 16'h0218};
    logic [15:0] qual [6] = '{16'h0000, 16'h0002, 16'h0000, 16'h000F, 16'h00FF, 16'h0000};
    int n_errors = 0;
    int checks_done = 0;
    int seed = 68;
    int i, lv;
    always #12.5 mclk = ~mclk;
    shrn_node i_dut (.MCLK(mclk), .RST(rst), .HUB_ENABLE(hub_enable), .REQ_VALID(req_valid),
        .REQ_INDIRECT(req_indirect), .REQ_WRITE(req_write), .REQ_OFFSET(req_offset), .REQ_LEVEL(req_level),
        .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_ERROR(rsp_error), .RSP_ERR_CODE(rsp_err_code),
        .RSP_LENGTH(rsp_length), .RSP_DATA(rsp_data), .ACCEL_VALID(accel_valid), .ACCEL_SAMPLE(accel_sample),
        .THERM_VALID(therm_valid), .THERM_SAMPLE(therm_sample), .PORT1_VALUE(port1), .PORT0_VALUE(port0));
    shrn_ctrl_model i_ctrl (.mclk(mclk), .hub_enable(hub_enable), .req_valid(req_valid),
        .req_indirect(req_indirect), .req_write(req_write), .req_offset(req_offset), .req_level(req_level),
        .req_ready(req_ready), .rsp_valid(rsp_valid));
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (n_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic run(input bit ans, input logic ind, input logic wr, input int off, input int lvl);
        bit got;
        int sel, cnt;
        logic [15:0] code;
        logic [3:0] len;
        logic [63:0] data;
        i_ctrl.request(ind, wr, off[14:0], lvl[3:0], got);
        sel = off % 128;
        cnt = (lvl >= 2) ? 12 : 11;
        code = 16'h0000;
        len = 4'h2;
        data = 64'h0000_0000_0000_0000;
        if (wr)
            code = ind ? 16'h1041 : 16'h1441;
        else if (!ind && sel == 0)
        begin
            len = 4'h8;
            data = 64'h4E4F_4445_2D30_3030;
        end
        else if (!ind)
            if (sel < 6) data[63:48] = qual[sel];
            else code = 16'h1340;
        else if (sel == 0)
            data[63:48] = cnt[15:0];
        else if (sel <= cnt)
            data[63:48] = leaf[sel];
        else
            code = 16'h1440;
        if (code != 16'h0000)
            len = 4'h0;
        check(got, ans);
        check(req_ready, !ans);
        if (ans)
        begin
            check(rsp_error, code != 16'h0000);
            check(rsp_err_code, code);
            check(rsp_length, len);
            check(rsp_data, data);
        end
    endtask
    task automatic sample(input logic [13:0] a, input logic [31:0] t, input bit en);
        @(posedge mclk);
        accel_valid <= 1'b1;
        accel_sample <= a;
        therm_valid <= 1'b1;
        therm_sample <= t;
        @(posedge mclk);
        accel_valid <= 1'b0;
        therm_valid <= 1'b0;
        @(negedge mclk);
        if (en)
        begin
            last_a = {{2{a[13]}}, a};
            last_t = t;
        end
        check(port1, last_a);
        check(port0, last_t);
    endtask
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        report_and_stop;
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        run(0, 1'b1, 1'b0, 0, 0);
        sample(14'h2000, 32'hFFFF_FFFF, 0);
        i_ctrl.set_hub(1'b1);
        sample(14'h2000, 32'h0003_32C0, 1);
        for (i = 0; i < 8; i++)
            run(1, 1'b0, 1'b0, i | (($random(seed) & 255) << 7), $random(seed) & 15);
        for (i = 0; i < 6; i++)
            run(1, 1'b0, 1'b1, $random(seed) & 32767, $random(seed) & 15);
        for (i = 0; i < 6; i++)
            run(1, 1'b1, 1'b1, $random(seed) & 32767, $random(seed) & 15);
        for (lv = 0; lv < 4; lv++)
            for (i = 0; i < 14; i++)
                run(1, 1'b1, 1'b0, i | (($random(seed) & 255) << 7), lv);
        run(1, 1'b1, 1'b0, 127, 2);
        for (i = 0; i < 8; i++)
            sample($random(seed), $random(seed), 1);
        i_ctrl.set_hub(1'b0);
        run(0, 1'b1, 1'b0, 1, 0);
        sample($random(seed), $random(seed), 0);
        report_and_stop;
    end
endmodule
